// [sasp_bit_timer.sv]
// Bit period timer with half-bit mark
`timescale 1ns/1ps
module sasp_bit_timer #(
  parameter int CW = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [CW-1:0] period,
  sasp_tick_if.timer tk
);
  logic [CW-1:0] cnt_q;

  // Restart aligns the count with a start edge or frame start
  always_ff @(posedge clk)
  begin
    if (sys_rst || tk.restart || cnt_q == period - 1'b1)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  assign tk.bit_tick = !tk.restart && cnt_q == period - 1'b1;
  assign tk.half_tick = !tk.restart && cnt_q == (period >> 1);
endmodule

// [sasp_map.svh]
// Constants for the soft asynchronous serial port
// Function
// - Start, eight data LSB first, stop
// - Wait start twenty characters, else return zero
// - Finish on count or twenty-character idle
// - Abandon receive on invalid stop bit
// - Transmit done after whole buffer sent
// - Receiver armed before quarter of start
// - Report bytes captured as unsigned count
// - One bit buffering, rate up to 4800
// - One input pin, one output pin
// - Rates 600, 1200, 2400, 4800; default 2400
// - Bit rate scales with core clock
// - Handshake pins recommended for coordination
// - Only one operation active, half duplex
// - Stop bit high, else error end
`ifndef SASP_MAP_SVH
`define SASP_MAP_SVH
`define SASP_CLK_HZ 100000000
`define SASP_REF_CLK_HZ 10000000
`define SASP_DATA_BITS 8
`define SASP_FRAME_BITS 10
`define SASP_TIMEOUT_CHARS 20
`define SASP_RATE_600 2'h0
`define SASP_RATE_1200 2'h1
`define SASP_RATE_2400 2'h2
`define SASP_RATE_4800 2'h3
`define SASP_RATE_DEFAULT 2'h2
`endif

// [sasp_pkg.sv]
// Types for the soft asynchronous serial port
package sasp_pkg;
  typedef enum logic [2:0] {
    SASP_IDLE = 3'b000,
    SASP_RX_WAIT = 3'b001,
    SASP_RX_BITS = 3'b010,
    SASP_TX_LOAD = 3'b011,
    SASP_TX_BITS = 3'b100
  } sasp_state_type;
endpackage

// [sasp_tb.sv]
// Testbench for the soft asynchronous serial port
`timescale 1ns/1ps
module tb;
  localparam int P = 10;
  localparam int AW = 3;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rx_start = 1'b0;
  logic tx_start = 1'b0;
  logic tx_wr_en = 1'b0;
  logic [AW-1:0] rx_len = 3'h0;
  logic [AW-1:0] tx_len = 3'h0;
  logic [AW-1:0] tx_wr_addr = 3'h0;
  logic [AW-1:0] rx_rd_addr = 3'h0;
  logic [7:0] tx_wr_data = 8'h00;
  logic [7:0] rx_rd_data;
  logic [AW-1:0] rx_count;
  logic serial_in, serial_out, busy, rx_done, rx_stop_err, tx_done;
  logic [7:0] pat[2] = '{8'ha5, 8'h3c};
  int num_errors = 0;
  int comparisons = 0;
  int n;
  // Slow core clock gives ten cycles a bit
  sasp_top #(.CLK_HZ(480000), .BUF_DEPTH(4), .RATE_SEL(2'h3)) i_sasp_top (.clk(clk),
    .sys_rst(sys_rst), .rx_start(rx_start), .rx_len(rx_len), .tx_start(tx_start),
    .tx_len(tx_len), .tx_wr_addr(tx_wr_addr), .tx_wr_data(tx_wr_data), .tx_wr_en(tx_wr_en),
    .rx_rd_addr(rx_rd_addr), .rx_rd_data(rx_rd_data), .serial_in(serial_in),
    .serial_out(serial_out), .busy(busy), .rx_done(rx_done), .rx_count(rx_count),
    .rx_stop_err(rx_stop_err), .tx_done(tx_done));
  sasp_term #(.P(P)) i_sasp_term (.clk(clk), .tx_line(serial_out), .line(serial_in));
  initial forever #5 clk = ~clk;
  task automatic chk(input string m, input logic [8:0] g, input logic [8:0] e);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic give_verdict();
    $display("Counts: %0d compared, %0d mismatched", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_done(input int lim);
    n = 0;
    while ((rx_done | tx_done) !== 1'b1)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim)
      begin
        num_errors++;
        $display("[ERR] %0t no done", $time);
        give_verdict();
      end
    end
  endtask
  task automatic go(input logic r, input logic [AW-1:0] len);
    @(posedge clk);
    rx_start <= r;
    tx_start <= ~r;
    rx_len <= len;
    tx_len <= len;
    @(posedge clk);
    rx_start <= 1'b0;
    tx_start <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [7:0] e);
    @(posedge clk);
    rx_rd_addr <= a;
    repeat (2) @(posedge clk);
    #1;
    chk("rx data", {1'b0, rx_rd_data}, {1'b0, e});
  endtask
  task automatic t_tx();
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      tx_wr_en <= 1'b1;
      tx_wr_addr <= i[AW-1:0];
      tx_wr_data <= pat[i];
    end
    @(posedge clk);
    tx_wr_en <= 1'b0;
    go(1'b0, 3'h2);
    wait_done(25 * P);
    chk("tx time", n >= 19 * P, 1'b1);
    chk("tx frames", i_sasp_term.got.size() == 2, 1'b1);
    chk("tx byte 0", i_sasp_term.got[0], {1'b1, pat[0]});
    chk("tx byte 1", i_sasp_term.got[1], {1'b1, pat[1]});
    $display("tx test ended");
  endtask
  // Frames start at once so the receiver is armed before the start bit
  task automatic t_rx();
    go(1'b1, 3'h2);
    fork
      begin
        i_sasp_term.send(pat[0], 1'b1);
        i_sasp_term.send(pat[1], 1'b1);
      end
    join_none
    wait_done(25 * P);
    chk("rx count", rx_count, 2);
    rd(3'h0, pat[0]);
    rd(3'h1, pat[1]);
    $display("rx test ended");
  endtask
  task automatic t_bad();
    go(1'b1, 3'h3);
    fork
      begin
        i_sasp_term.send(8'h5a, 1'b0);
        i_sasp_term.send(pat[0], 1'b1);
      end
    join_none
    wait_done(11 * P);
    chk("stop error", rx_stop_err, 1'b1);
    chk("bad count", rx_count, 0);
    repeat (11 * P) @(posedge clk);
    $display("bad stop test ended");
  endtask
  // Idle timer must restart after the byte, so the end comes late
  task automatic t_idle();
    go(1'b1, 3'h3);
    chk("error cleared", rx_stop_err, 1'b0);
    fork
      i_sasp_term.send(pat[1], 1'b1);
    join_none
    wait_done(215 * P);
    chk("idle time", n >= 205 * P, 1'b1);
    chk("idle count", rx_count, 1);
    rd(3'h0, pat[1]);
    $display("idle test ended");
  endtask
  task automatic t_none();
    go(1'b1, 3'h2);
    wait_done(210 * P);
    chk("wait time", n >= 198 * P, 1'b1);
    chk("none count", rx_count, 0);
    $display("no start test ended");
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("reset", {serial_out, busy, rx_stop_err, rx_count}, 6'h20);
    t_tx();
    t_rx();
    t_bad();
    t_idle();
    t_none();
    give_verdict();
  end
endmodule

// [sasp_term.sv]
// Serial terminal model facing the port's pins
`timescale 1ns/1ps
module sasp_term #(
  parameter int P = 10
) (
  input wire logic clk,
  input wire logic tx_line,
  output logic line
);
  logic [8:0] got[$];
  logic [8:0] f;
  initial line = 1'b1;
  // Stop level is a choice so a faulty frame can be made
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] w;
    w = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line <= w[i];
      repeat (P) @(posedge clk);
    end
    // A low stop bit is ended by one idle cycle so the next start still falls
    if (!stop)
    begin
      line <= 1'b1;
      @(posedge clk);
    end
  endtask
  // Mid-bit sampling; stop bit kept in the top bit
  initial
  forever
  begin
    @(negedge tx_line);
    repeat (P / 2) @(posedge clk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (P) @(posedge clk);
      f[i] = tx_line;
    end
    got.push_back(f);
  end
endmodule

// [sasp_tick_if.sv]
// Bit timing link between port core and bit timer
`timescale 1ns/1ps
interface sasp_tick_if;
  logic restart;
  logic half_tick;
  logic bit_tick;
  modport core (output restart, input half_tick, input bit_tick);
  modport timer (input restart, output half_tick, output bit_tick);
endinterface

// [sasp_top.sv]
// Half-duplex soft asynchronous serial port
`timescale 1ns/1ps
`include "sasp_map.svh"
module sasp_top #(
  parameter int CLK_HZ = `SASP_CLK_HZ,
  parameter int BUF_DEPTH = 32,
  parameter int AW = $clog2(BUF_DEPTH + 1),
  parameter logic [1:0] RATE_SEL = `SASP_RATE_DEFAULT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rx_start,
  input wire logic [AW-1:0] rx_len,
  input wire logic tx_start,
  input wire logic [AW-1:0] tx_len,
  input wire logic [AW-1:0] tx_wr_addr,
  input wire logic [7:0] tx_wr_data,
  input wire logic tx_wr_en,
  input wire logic [AW-1:0] rx_rd_addr,
  output logic [7:0] rx_rd_data,
  input wire logic serial_in,
  output logic serial_out,
  output logic busy,
  output logic rx_done,
  output logic [AW-1:0] rx_count,
  output logic rx_stop_err,
  output logic tx_done
);
  localparam int CW = 20;
  localparam int SW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int TOUT_BITS = `SASP_TIMEOUT_CHARS * `SASP_FRAME_BITS;
  localparam int TW = $clog2(TOUT_BITS + 1);
  localparam logic [3:0] LAST_BIT = 4'(`SASP_FRAME_BITS - 1);
  localparam logic [TW-1:0] TOUT_LAST = TW'(TOUT_BITS - 1);

  // Rate is the setting times the nominal clock ratio; the cycle count per bit is
  // fixed at build time, so the real rate follows the clock actually applied
  function automatic logic [CW-1:0] period_of(input logic [1:0] sel);
    longint unsigned r;
    r = (64'd600 << sel) * 64'(`SASP_CLK_HZ / `SASP_REF_CLK_HZ);
    return CW'(longint'(CLK_HZ) / r);
  endfunction

  // Buffer slot of a byte index; callers only pass indices below BUF_DEPTH
  function automatic logic [SW-1:0] slot_of(input logic [AW-1:0] a);
    return SW'(a);
  endfunction

  function automatic logic in_buf(input logic [AW-1:0] a);
    return a < AW'(BUF_DEPTH);
  endfunction

  // Lengths beyond the buffer are cut to its depth
  function automatic logic [AW-1:0] clamp_len(input logic [AW-1:0] n);
    return (n > AW'(BUF_DEPTH)) ? AW'(BUF_DEPTH) : n;
  endfunction

  localparam logic [CW-1:0] PERIOD = period_of(RATE_SEL);

  sasp_tick_if tk ();
  sasp_pkg::sasp_state_type st_q;
  logic [7:0] txbuf_q [BUF_DEPTH];
  logic [7:0] rxbuf_q [BUF_DEPTH];
  logic [AW-1:0] len_q;
  logic [AW-1:0] idx_q;
  logic [3:0] bit_q;
  logic [9:0] shift_q;
  logic [TW-1:0] tout_q;
  logic restart_q;
  logic rx_prev_q;
  logic rx_fall;
  logic rx_take;
  logic tx_take;
  logic rx_full;
  logic rx_edge;
  logic rx_tick;
  logic rx_tout;
  logic rx_samp;
  logic rx_last;
  logic rx_bad;
  logic rx_store;
  logic rx_glitch;
  logic rx_end;
  logic tx_fin;
  logic tx_frame;
  logic tx_tick;
  logic tx_next;
  logic tx_shift;

  sasp_bit_timer #(.CW(CW)) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .period(PERIOD),
    .tk(tk)
  );
  assign tk.restart = restart_q;

  assign rx_fall = rx_prev_q && !serial_in;
  assign rx_take = st_q == sasp_pkg::SASP_IDLE && rx_start;
  assign tx_take = st_q == sasp_pkg::SASP_IDLE && !rx_start && tx_start;
  assign rx_full = st_q == sasp_pkg::SASP_RX_WAIT && idx_q == len_q;
  // Armed the cycle after the request, far inside the first quarter bit
  assign rx_edge = st_q == sasp_pkg::SASP_RX_WAIT && !rx_full && rx_fall;
  assign rx_tick = st_q == sasp_pkg::SASP_RX_WAIT && !rx_full && !rx_fall && tk.bit_tick;
  assign rx_tout = rx_tick && tout_q == TOUT_LAST;
  assign rx_samp = st_q == sasp_pkg::SASP_RX_BITS && tk.half_tick;
  assign rx_last = rx_samp && bit_q == LAST_BIT;
  assign rx_bad = rx_last && !serial_in;
  assign rx_store = rx_last && serial_in;
  // A start bit already high again at mid-bit was only a glitch
  assign rx_glitch = rx_samp && bit_q == 4'h0 && serial_in;
  assign rx_end = rx_full || rx_tout || rx_bad;
  assign tx_fin = st_q == sasp_pkg::SASP_TX_LOAD && idx_q == len_q;
  assign tx_frame = st_q == sasp_pkg::SASP_TX_LOAD && idx_q != len_q;
  assign tx_tick = st_q == sasp_pkg::SASP_TX_BITS && tk.bit_tick;
  assign tx_next = tx_tick && bit_q == LAST_BIT;
  assign tx_shift = tx_tick && bit_q != LAST_BIT;

  // Previous input level; the single bit of buffering on the receive path
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rx_prev_q <= 1'b1;
    else
      rx_prev_q <= serial_in;
  end

  // Transmit buffer written by the user side; not guarded against writes while sending
  always_ff @(posedge clk)
  begin
    if (tx_wr_en && in_buf(tx_wr_addr))
      txbuf_q[slot_of(tx_wr_addr)] <= tx_wr_data;
  end

  // Receive buffer; a byte is kept only once its stop bit is good
  always_ff @(posedge clk)
  begin
    if (rx_store)
      rxbuf_q[slot_of(idx_q)] <= shift_q[9:2];
  end

  // Receive buffer readback, registered
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rx_rd_data <= 8'h00;
    else if (in_buf(rx_rd_addr))
      rx_rd_data <= rxbuf_q[slot_of(rx_rd_addr)];
    else
      rx_rd_data <= 8'h00;
  end

  // Sequencer; receive and transmit share it so they never overlap
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      st_q <= sasp_pkg::SASP_IDLE;
    else
    begin
      case (st_q)
        sasp_pkg::SASP_IDLE:
        begin
          if (rx_take)
            st_q <= sasp_pkg::SASP_RX_WAIT;
          else if (tx_take)
            st_q <= sasp_pkg::SASP_TX_LOAD;
        end
        sasp_pkg::SASP_RX_WAIT:
        begin
          if (rx_full || rx_tout)
            st_q <= sasp_pkg::SASP_IDLE;
          else if (rx_edge)
            st_q <= sasp_pkg::SASP_RX_BITS;
        end
        sasp_pkg::SASP_RX_BITS:
        begin
          if (rx_bad)
            st_q <= sasp_pkg::SASP_IDLE;
          else if (rx_store || rx_glitch)
            st_q <= sasp_pkg::SASP_RX_WAIT;
        end
        sasp_pkg::SASP_TX_LOAD:
        begin
          if (tx_fin)
            st_q <= sasp_pkg::SASP_IDLE;
          else
            st_q <= sasp_pkg::SASP_TX_BITS;
        end
        sasp_pkg::SASP_TX_BITS:
        begin
          if (tx_next)
            st_q <= sasp_pkg::SASP_TX_LOAD;
        end
        default:
          st_q <= sasp_pkg::SASP_IDLE;
      endcase
    end
  end

  // Requested length, taken with the start request
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      len_q <= '0;
    else if (rx_take)
      len_q <= clamp_len(rx_len);
    else if (tx_take)
      len_q <= clamp_len(tx_len);
  end

  // Byte index into either buffer
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      idx_q <= '0;
    else if (rx_take || tx_take)
      idx_q <= '0;
    else if (rx_store || tx_next)
      idx_q <= idx_q + 1'b1;
  end

  // Bit position within the frame
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      bit_q <= 4'h0;
    else if (rx_edge || tx_frame)
      bit_q <= 4'h0;
    else if (rx_samp || tx_shift)
      bit_q <= bit_q + 4'h1;
  end

  // Frame shifter; receive fills from the top, so the byte ends in bits 9 to 2
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      shift_q <= 10'h3ff;
    else if (rx_samp)
      shift_q <= {serial_in, shift_q[9:1]};
    else if (tx_frame)
      shift_q <= {1'b1, txbuf_q[slot_of(idx_q)], 1'b0};
  end

  // Idle timer in bit periods, restarted by each receive request and each received byte
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      tout_q <= '0;
    else if (rx_take || rx_last)
      tout_q <= '0;
    else if (rx_tick)
      tout_q <= tout_q + 1'b1;
  end

  // Timer realigned at each receive request, start edge and outgoing frame
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      restart_q <= 1'b1;
    else
      restart_q <= rx_take || rx_edge || tx_frame;
  end

  // Output line; stays high outside frames
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      serial_out <= 1'b1;
    else if (st_q == sasp_pkg::SASP_IDLE)
      serial_out <= 1'b1;
    else if (tx_frame)
      serial_out <= 1'b0;
    else if (tx_shift)
      serial_out <= shift_q[bit_q + 4'h1];
  end

  // Busy also tells a handshaking sender that the receiver is listening
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      busy <= 1'b0;
    else if (st_q == sasp_pkg::SASP_IDLE)
      busy <= rx_take || tx_take;
    else if (tx_fin)
      busy <= 1'b0;
  end

  // Completion pulses, one cycle each
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rx_done <= 1'b0;
      tx_done <= 1'b0;
    end
    else
    begin
      rx_done <= rx_end;
      tx_done <= tx_fin;
    end
  end

  // Bytes captured, held until the next receive ends
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rx_count <= '0;
    else if (rx_end)
      rx_count <= idx_q;
  end

  // Stop error flag, cleared by the next receive request
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rx_stop_err <= 1'b0;
    else if (rx_bad)
      rx_stop_err <= 1'b1;
    else if (rx_take)
      rx_stop_err <= 1'b0;
  end
endmodule

// [sasp_top_properties.sv]
// Port-level timing checks for the serial port
`timescale 1ns/1ps
module sasp_chk #(
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rx_start,
  input wire logic tx_start,
  input wire logic [AW-1:0] tx_len,
  input wire logic serial_out,
  input wire logic busy,
  input wire logic rx_done,
  input wire logic [AW-1:0] rx_count,
  input wire logic rx_stop_err,
  input wire logic tx_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_idle_high: assert property (!busy |-> serial_out) else $error("idle line low");
  a_start_bit: assert property (!busy && tx_start && !rx_start && tx_len != 0 |-> ##2 !serial_out)
    else $error("no start bit");
  a_start_busy: assert property (!busy && (rx_start || tx_start) |=> busy)
    else $error("start not taken");
  a_one_op: assert property (!(rx_done && tx_done)) else $error("two ops");
  a_tx_end: assert property (tx_done |=> !busy && !tx_done) else $error("tx end");
  a_rx_pulse: assert property (rx_done |=> !rx_done) else $error("rx pulse");
  a_rx_from: assert property (rx_done |-> $past(busy)) else $error("rx done idle");
  a_count_hold: assert property (!busy && !$past(busy) |-> $stable(rx_count))
    else $error("count moved");
  a_err_done: assert property ($rose(rx_stop_err) |-> ##[0:1] rx_done)
    else $error("error without end");
  c_rx: cover property (rx_done && rx_count != 0);
  c_err: cover property (rx_stop_err && rx_done);
  c_tx: cover property (tx_done);
endmodule
bind sasp_top sasp_chk #(.AW(AW)) i_sasp_chk (.*);
